// *** bench/msj_fb_master.sv ***
// Fieldbus master model: parameter reads and writes.
// One request pulse; answer taken a cycle later.
`timescale 1ns/1ps
module msj_fb_master
(
  // Clock
  input  wire logic        clk_sys,
  // Parameter port
  output logic             par_req,
  output logic             par_we,
  output logic      [15:0] par_addr,
  output logic      [31:0] par_wdata,
  input  wire logic        par_ack,
  input  wire logic        par_err,
  input  wire logic [31:0] par_rdata
);
  initial
  begin
    par_req   = 1'b0;
    par_we    = 1'b0;
    par_addr  = 16'h0000;
    par_wdata = 32'h00000000;
  end

  task automatic access(input logic we, input logic [15:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic er);
    @(posedge clk_sys);
    par_req   <= 1'b1;
    par_we    <= we;
    par_addr  <= a;
    par_wdata <= d;
    @(posedge clk_sys);
    // Inverted so a late sample cannot pass
    par_req   <= 1'b0;
    par_addr  <= ~a;
    par_wdata <= ~d;
    @(posedge clk_sys);
    rd = par_rdata;
    er = par_ack === 1'b1 ? par_err : 1'bx;
  endtask
endmodule

// *** bench/msj_stop_ctrl_bench.sv ***
// Bench for the stop controller.
// Inputs change by NBA on rising edges.
`timescale 1ns/1ps
module msj_stop_ctrl_bench;
  logic               clk_sys = 1'b0;
  logic               rst = 1'b1;
  logic               par_req, par_we, par_ack, par_err;
  logic        [15:0] par_addr;
  logic        [31:0] par_wdata, par_rdata;
  logic               halt_pin = 1'b0, halt_pin_assigned = 1'b0, halt_fieldbus = 1'b0;
  logic               qs_fieldbus = 1'b0, err_event = 1'b0, qs_release = 1'b0;
  logic               motion_start = 1'b0, standstill = 1'b0;
  logic               mode_finished = 1'b1, mode_has_profile = 1'b1;
  logic        [2:0]  err_class = 3'h0;
  logic        [31:0] profile_decel_rate = 32'h00012345;
  logic signed [31:0] acc_demand = 32'sh0;
  logic               halt_active, qs_active, stop_active, stop_use_torque;
  logic               resume_pulse, op_state_valid;
  logic        [31:0] stop_decel_rate;
  logic        [15:0] stop_current_limit, jerk_time_active;
  logic signed [31:0] acc_filtered;
  logic        [3:0]  op_state_req;
  int                 fails = 0;
  int                 check_count = 0;

  always #2.5 clk_sys = ~clk_sys;

  // Short tick keeps filter decay brief
  msj_stop_ctrl #(.TICK_CYCLES(20)) u_msj_stop_ctrl
  (
    .clk_sys, .rst, .par_req, .par_we, .par_addr, .par_wdata, .par_ack, .par_err,
    .par_rdata, .halt_pin, .halt_pin_assigned, .halt_fieldbus, .qs_fieldbus,
    .err_event, .err_class, .qs_release, .mode_finished, .motion_start, .standstill,
    .mode_has_profile, .profile_decel_rate, .acc_demand, .halt_active, .qs_active,
    .stop_active, .stop_use_torque, .stop_decel_rate, .stop_current_limit,
    .resume_pulse, .acc_filtered, .jerk_time_active, .op_state_req, .op_state_valid
  );

  msj_fb_master u_msj_fb_master
  (
    .clk_sys, .par_req, .par_we, .par_addr, .par_wdata, .par_ack, .par_err, .par_rdata
  );

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic chk1(input string what, input logic seen, input logic exp);
    chk(what, {31'h0, seen}, {31'h0, exp});
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic e);
    logic [31:0] v;
    logic        er;
    u_msj_fb_master.access(1'b1, a, d, v, er);
    chk1("write refused", er, e);
  endtask

  task automatic rd(input logic [15:0] a, input logic [31:0] x);
    logic [31:0] v;
    logic        er;
    u_msj_fb_master.access(1'b0, a, 32'h0, v, er);
    chk("read data", v, x);
    chk1("read refused", er, 1'b0);
  endtask

  task automatic move();
    motion_start <= 1'b1;
    cyc(1);
    motion_start <= 1'b0;
    cyc(2);
  endtask

  task automatic wait_resume();
    for (int n = 0; n < 10 && resume_pulse !== 1'b1; n++)
      cyc(1);
    chk1("resume", resume_pulse, 1'b1);
    standstill <= 1'b0;
    cyc(1);
    chk1("stop left", stop_active, 1'b0);
  endtask

  task automatic t_regs();
    logic [31:0] v;
    logic        er;
    rd(msj_pkg::ADDR_JERK, 32'h00000000);
    rd(msj_pkg::ADDR_QS_RATE, 32'h00001770);
    rd(msj_pkg::ADDR_HALT_SEL, 32'h00000003);
    rd(msj_pkg::ADDR_QS_SEL, 32'h00000007);
    rd(msj_pkg::ADDR_QS_ILIM, {16'h0, msj_pkg::QS_ILIM_RST});
    rd(msj_pkg::ADDR_HALT_ILIM, {16'h0, msj_pkg::HALT_ILIM_RST});
    u_msj_fb_master.access(1'b0, 16'h0000, 32'h0, v, er);
    chk1("unmapped read", er, 1'b1);
    wr(msj_pkg::ADDR_QS_RATE, 32'h000000c7, 1'b1);
    wr(msj_pkg::ADDR_QS_RATE, 32'h000000c8, 1'b0);
    wr(msj_pkg::ADDR_QS_RATE, 32'h002dc6c1, 1'b1);
    wr(msj_pkg::ADDR_QS_RATE, 32'h002dc6c0, 1'b0);
    rd(msj_pkg::ADDR_QS_RATE, 32'h002dc6c0);
    wr(msj_pkg::ADDR_HALT_SEL, 32'h00000002, 1'b1);
    wr(msj_pkg::ADDR_QS_SEL, 32'h00000005, 1'b1);
    wr(msj_pkg::ADDR_QS_ILIM, 32'h0000ffff, 1'b0);
    rd(msj_pkg::ADDR_QS_ILIM, 32'h0000ffff);
  endtask

  task automatic t_jerk();
    logic [15:0] c;
    for (int i = 0; i < 9; i++)
    begin
      c = i == 0 ? 16'h0 : 16'h1 << (i - 1);
      wr(msj_pkg::ADDR_JERK, {16'h0, c}, 1'b0);
      rd(msj_pkg::ADDR_JERK, {16'h0, c});
    end
    wr(msj_pkg::ADDR_JERK, 32'h00000003, 1'b1);
    wr(msj_pkg::ADDR_JERK, 32'h00000100, 1'b1);
    mode_finished <= 1'b0;
    wr(msj_pkg::ADDR_JERK, 32'h00000004, 1'b1);
    mode_finished <= 1'b1;
    rd(msj_pkg::ADDR_JERK, 32'h00000080);
    chk("jerk before move", {16'h0, jerk_time_active}, 32'h0);
    move();
    chk("jerk after move", {16'h0, jerk_time_active}, 32'h00000080);
    wr(msj_pkg::ADDR_JERK, 32'h00000000, 1'b0);
    move();
    acc_demand <= 32'sd1000;
    cyc(2);
    chk("filter off", acc_filtered, 32'sd1000);
    wr(msj_pkg::ADDR_JERK, 32'h00000002, 1'b0);
    move();
    acc_demand <= 32'sd0;
    cyc(2);
    chk1("filter slows", acc_filtered == 1000 || acc_filtered == 500, 1'b1);
    cyc(1200);
    chk("filter settles", acc_filtered, 32'sd0);
  endtask

  task automatic t_halt();
    logic [15:0] sel [3] = '{16'h1, 16'h3, 16'h1};
    logic        prof [3] = '{1'b1, 1'b1, 1'b0};
    wr(msj_pkg::ADDR_HALT_ILIM, 32'h0000abcd, 1'b0);
    for (int i = 0; i < 3; i++)
    begin
      wr(msj_pkg::ADDR_HALT_SEL, {16'h0, sel[i]}, 1'b0);
      mode_has_profile <= prof[i];
      halt_fieldbus    <= 1'b1;
      cyc(2);
      chk1("halt", halt_active, 1'b1);
      chk1("halt torque", stop_use_torque, sel[i] == 16'h3 || !prof[i]);
      if (sel[i] == 16'h1 && prof[i])
        chk("halt rate", stop_decel_rate, 32'h00012345);
      else
        chk("halt limit", {16'h0, stop_current_limit}, 32'h0000abcd);
      halt_fieldbus <= 1'b0;
      cyc(3);
      chk1("halt kept", halt_active, 1'b1);
      standstill <= 1'b1;
      wait_resume();
    end
  endtask

  task automatic t_pin();
    halt_pin <= 1'b1;
    cyc(8);
    chk1("pin not assigned", halt_active, 1'b0);
    halt_pin_assigned <= 1'b1;
    cyc(8);
    chk1("pin halt", halt_active, 1'b1);
    standstill <= 1'b1;
    cyc(3);
    chk1("pin halt parked", halt_active, 1'b1);
    halt_pin <= 1'b0;
    wait_resume();
  endtask

  task automatic t_qs();
    logic [15:0] code [4] = '{16'hfffe, 16'hffff, 16'h0006, 16'h0007};
    logic        tq;
    mode_has_profile <= 1'b1;
    wr(msj_pkg::ADDR_QS_RATE, 32'h000000c8, 1'b0);
    move();
    wr(msj_pkg::ADDR_QS_ILIM, 32'h00001234, 1'b0);
    err_event <= 1'b1;
    err_class <= 3'h3;
    cyc(1);
    err_event <= 1'b0;
    cyc(2);
    chk1("class 3 ignored", qs_active, 1'b0);
    for (int i = 0; i < 4; i++)
    begin
      tq = code[i] == 16'hfffe || code[i] == 16'h0007;
      wr(msj_pkg::ADDR_QS_SEL, {16'h0, code[i]}, 1'b0);
      err_class   <= i == 1 ? 3'h1 : 3'h2;
      err_event   <= i == 1 || i == 2;
      qs_fieldbus <= i == 0 || i == 3;
      cyc(1);
      err_event   <= 1'b0;
      qs_fieldbus <= 1'b0;
      cyc(1);
      chk1("quick stop", qs_active, 1'b1);
      chk1("qs torque", stop_use_torque, tq);
      if (tq)
        chk("qs limit", {16'h0, stop_current_limit}, 32'h00001234);
      else
        chk("qs rate", stop_decel_rate, 32'h000000c8);
      standstill <= 1'b1;
      for (int n = 0; n < 10 && op_state_valid !== 1'b1; n++)
        cyc(1);
      chk("parked state", {28'h0, op_state_req}, i < 2 ? 32'h9 : 32'h7);
      standstill <= 1'b0;
      qs_release <= 1'b1;
      cyc(1);
      qs_release <= 1'b0;
      cyc(2);
      chk1("qs left", qs_active, 1'b0);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    cyc(3);
    rst <= 1'b0;
    cyc(1);
    t_regs();
    t_jerk();
    t_halt();
    t_pin();
    t_qs();
    wrap_up();
  end

  // Run needs under two thousand cycles
  initial
  begin
    cyc(40000);
    fails++;
    wrap_up();
  end
endmodule

// *** bench/msj_stop_ctrl_properties.sv ***
// Checker on the stop controller ports.
// One clock domain.
`timescale 1ns/1ps
module msj_stop_props
(
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        rst,
  // Stop sources and profile status
  input wire logic        halt_fieldbus,
  input wire logic        qs_fieldbus,
  input wire logic        err_event,
  input wire logic [2:0]  err_class,
  input wire logic        qs_release,
  input wire logic        standstill,
  input wire logic        mode_has_profile,
  input wire logic        motion_start,
  input wire logic [31:0] profile_decel_rate,
  // Stop outputs
  input wire logic        halt_active,
  input wire logic        qs_active,
  input wire logic        stop_active,
  input wire logic        stop_use_torque,
  input wire logic [31:0] stop_decel_rate,
  input wire logic        resume_pulse,
  input wire logic [15:0] jerk_time_active,
  input wire logic [3:0]  op_state_req,
  input wire logic        op_state_valid
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  logic seen_still_r;
  logic qs_trig;

  assign qs_trig = qs_fieldbus || (err_event && (err_class == msj_pkg::ERR_CLASS_1
                   || err_class == msj_pkg::ERR_CLASS_2));

  // Standstill seen during this halt
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      seen_still_r <= 1'b0;
    else if (!halt_active)
      seen_still_r <= 1'b0;
    else if (standstill)
      seen_still_r <= 1'b1;
  end

  a_halt_entry: assert property (
    halt_fieldbus && !stop_active && !qs_trig |=> halt_active)
    else $error("halt command not taken");
  a_resume_after_still: assert property (
    resume_pulse |-> seen_still_r && !stop_active ##1 !resume_pulse)
    else $error("resume without standstill");
  a_halt_ramp_rate: assert property (
    halt_active && !stop_use_torque |-> stop_decel_rate == $past(profile_decel_rate))
    else $error("halt ramp not profile rate");
  a_no_profile_torque: assert property (
    $rose(stop_active) && !$past(mode_has_profile) |-> stop_use_torque)
    else $error("ramp used without profile");
  a_qs_entry: assert property (
    qs_trig && !qs_active |=> qs_active)
    else $error("quick stop not started");
  a_qs_stays: assert property (
    qs_active && !qs_release |=> qs_active)
    else $error("quick stop left early");
  a_park_code: assert property (
    op_state_valid |-> qs_active && (op_state_req == msj_pkg::OPST_QS_ACTIVE
      || op_state_req == msj_pkg::OPST_FAULT))
    else $error("bad parked state");
  a_park_after_still: assert property (
    $rose(op_state_valid) |-> $past(standstill))
    else $error("parked before standstill");
  a_jerk_latch: assert property (
    !$stable(jerk_time_active) |-> $past(motion_start, 2))
    else $error("jerk code changed mid movement");

  c_resume: cover property (resume_pulse);
  c_fault: cover property ($rose(op_state_valid) && op_state_req == 4'h9);
  c_hold: cover property ($rose(op_state_valid) && op_state_req == 4'h7);
endmodule

bind msj_stop_ctrl msj_stop_props u_msj_stop_props
(
  .clk_sys, .rst, .halt_fieldbus, .qs_fieldbus, .err_event, .err_class, .qs_release,
  .standstill, .mode_has_profile, .motion_start, .profile_decel_rate, .halt_active,
  .qs_active, .stop_active, .stop_use_torque, .stop_decel_rate, .resume_pulse,
  .jerk_time_active, .op_state_req, .op_state_valid
);

// *** rtl/msj_jerk_filter.sv ***
// First-order jerk filter on the acceleration demand.
// Assumes tick pulses once per millisecond; time constant is 2**shift ms.
`timescale 1ns/1ps
module msj_jerk_filter
(
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // Controller side
  msj_jerk_if.filt  jif
);

  logic signed [32:0] diff;
  logic signed [32:0] step;
  logic signed [32:0] sum;

  always_comb
  begin
    diff = 33'(jif.acc_in) - 33'(jif.acc_out);
    step = diff >>> jif.shift;
    sum  = 33'(jif.acc_out) + step;
  end

  // Off passes the demand straight through
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      jif.acc_out <= 32'sh0;
    else if (!jif.enable)
      jif.acc_out <= jif.acc_in;
    else if (jif.tick)
      jif.acc_out <= sum[31:0];
  end

endmodule

// *** rtl/msj_jerk_if.sv ***
// Carrier between the stop controller and its jerk filter.
// Both ends run on the same system clock.
`timescale 1ns/1ps
interface msj_jerk_if;
  logic               tick;
  logic               enable;
  logic        [2:0]  shift;
  logic signed [31:0] acc_in;
  logic signed [31:0] acc_out;

  modport ctrl (output tick, output enable, output shift, output acc_in, input acc_out);
  modport filt (input tick, input enable, input shift, input acc_in, output acc_out);
endinterface

// *** rtl/msj_pkg.sv ***
// Constants, parameter map and state type for the motion stop and jerk block.
// Assumes a 200 MHz clock and a fieldbus parameter port.
package msj_pkg;

  // Parameter addresses as the fieldbus sees them
  localparam logic [15:0] ADDR_JERK      = 16'h061a;
  localparam logic [15:0] ADDR_QS_RATE   = 16'h0624;
  localparam logic [15:0] ADDR_HALT_SEL  = 16'h062e;
  localparam logic [15:0] ADDR_QS_SEL    = 16'h0630;
  localparam logic [15:0] ADDR_QS_ILIM   = 16'h110a;
  localparam logic [15:0] ADDR_HALT_ILIM = 16'h110c;

  // Values after reset
  localparam logic [15:0] JERK_RST      = 16'h0000;
  localparam logic [31:0] QS_RATE_RST   = 32'h00001770;
  localparam logic [15:0] HALT_SEL_RST  = 16'h0003;
  localparam logic [15:0] QS_SEL_RST    = 16'h0007;
  localparam logic [15:0] QS_ILIM_RST   = 16'h0064;
  localparam logic [15:0] HALT_ILIM_RST = 16'h0064;

  // Halt deceleration codes
  localparam logic [15:0] HALT_DECEL  = 16'h0001;
  localparam logic [15:0] HALT_TORQUE = 16'h0003;

  // Quick stop reaction codes, signed 16 bit
  localparam logic [15:0] QS_TQ_FAULT  = 16'hfffe;
  localparam logic [15:0] QS_DEC_FAULT = 16'hffff;
  localparam logic [15:0] QS_DEC_HOLD  = 16'h0006;
  localparam logic [15:0] QS_TQ_HOLD   = 16'h0007;

  // Quick stop ramp range in RPM/s
  localparam logic [31:0] QS_RATE_MIN = 32'h000000c8;
  localparam logic [31:0] QS_RATE_MAX = 32'h002dc6c0;

  // Operating states requested after a quick stop
  localparam logic [3:0] OPST_QS_ACTIVE = 4'h7;
  localparam logic [3:0] OPST_FAULT     = 4'h9;

  // Error classes that start a quick stop
  localparam logic [2:0] ERR_CLASS_1 = 3'h1;
  localparam logic [2:0] ERR_CLASS_2 = 3'h2;

  // Jerk filter step: one update per millisecond
  localparam int CLK_MHZ      = 200;
  localparam int TICK_TIME_US = 1000;
  localparam int TICK_CYCLES  = TICK_TIME_US * CLK_MHZ;

  typedef enum logic [2:0] {
    ST_RUN,
    ST_HALT_DEC,
    ST_HALT_STOP,
    ST_QS_DEC,
    ST_QS_HOLD,
    ST_FAULT
  } msj_state_t;

endpackage

// *** rtl/msj_stop_ctrl.sv ***
// Halt, quick stop and jerk limit control for the velocity motion profile.
// Assumes the profile generator reports standstill and motion start,
// and the state machine acts on the requested state.
`timescale 1ns/1ps

// How it works
// - Jerk code 0 is off; 1..128 powers of two give that filter time in ms.
// - Jerk code accepted only with mode finished; applied at next movement start.
// - Halt stops the movement; clearing halt resumes it.
// - Halt comes from the digital input or the fieldbus command.
// - Halt cleared during deceleration: stop fully first, then accelerate back.
// - Halt selector: 1 deceleration ramp, 3 torque ramp; reset 3; immediate.
// - Halt deceleration ramp uses the profile deceleration rate.
// - Without a velocity profile both stops fall back to the torque ramp.
// - Halt and quick stop current limits: unsigned 16 bit, 0.01 A, immediate.
// - Quick stop starts on fieldbus command or on error class 1 or 2.
// - After quick stop standstill request state 7 or state 9 as configured.
// - Reaction -2 torque/fault, -1 ramp/fault, 6 ramp/hold, 7 torque/hold.
// - Quick stop rate 200..3000000 RPM/s, reset 6000, applied next movement.
module msj_stop_ctrl
#(
  parameter int TICK_CYCLES = msj_pkg::TICK_CYCLES
)
(
  // Clock and reset
  input  wire logic               clk_sys,
  input  wire logic               rst,
  // Fieldbus parameter port
  input  wire logic               par_req,
  input  wire logic               par_we,
  input  wire logic        [15:0] par_addr,
  input  wire logic        [31:0] par_wdata,
  output logic                    par_ack,
  output logic                    par_err,
  output logic             [31:0] par_rdata,
  // Halt sources
  input  wire logic               halt_pin,
  input  wire logic               halt_pin_assigned,
  input  wire logic               halt_fieldbus,
  // Quick stop sources
  input  wire logic               qs_fieldbus,
  input  wire logic               err_event,
  input  wire logic        [2:0]  err_class,
  input  wire logic               qs_release,
  // Profile generator status
  input  wire logic               mode_finished,
  input  wire logic               motion_start,
  input  wire logic               standstill,
  input  wire logic               mode_has_profile,
  input  wire logic        [31:0] profile_decel_rate,
  input  wire logic signed [31:0] acc_demand,
  // Stop commands to the profile generator
  output logic                    halt_active,
  output logic                    qs_active,
  output logic                    stop_active,
  output logic                    stop_use_torque,
  output logic             [31:0] stop_decel_rate,
  output logic             [15:0] stop_current_limit,
  output logic                    resume_pulse,
  output logic signed [31:0]      acc_filtered,
  output logic             [15:0] jerk_time_active,
  // Operating-state request
  output logic             [3:0]  op_state_req,
  output logic                    op_state_valid
);

  // Parameter storage
  logic [15:0] jerk_filter_time_r;
  logic [31:0] quickstop_decel_rate_r;
  logic [15:0] halt_reaction_select_r;
  logic [15:0] quickstop_reaction_select_r;
  logic [15:0] quickstop_current_limit_r;
  logic [15:0] halt_current_limit_r;
  // Copies taken at the start of a movement
  logic [15:0] jerk_act_r;
  logic [31:0] qs_rate_act_r;

  msj_pkg::msj_state_t state_r;
  msj_pkg::msj_state_t state_nxt;

  logic [2:0]  halt_sync_r;
  logic        halt_din_r;
  logic [17:0] tick_cnt_r;
  logic        tick_r;

  logic        halt_req;
  logic        qs_trig;
  logic        qs_to_fault;
  logic        qs_torque;
  logic        halt_torque;
  logic        wr_ok;
  logic        addr_ok;
  logic [31:0] rd_val;
  logic [3:0]  wr_dec;

  msj_jerk_if jif ();

  // Only the eight listed powers of two decode as filter on
  function automatic logic [3:0] jerk_decode(input logic [15:0] code);
    logic [3:0] res;
    res = 4'h0;
    for (int i = 0; i < 8; i++)
    begin
      if (code == (16'h0001 << i))
        res = {1'b1, 3'(i)};
    end
    return res;
  endfunction

  assign wr_dec = jerk_decode(par_wdata[15:0]);

  // A level counts once stages two and three agree
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      halt_sync_r <= 3'h0;
      halt_din_r  <= 1'b0;
    end
    else
    begin
      halt_sync_r <= {halt_sync_r[1:0], halt_pin};
      if (halt_sync_r[1] == halt_sync_r[2])
        halt_din_r <= halt_sync_r[2];
    end
  end

  // Pin ignored unless assigned the halt function
  assign halt_req = (halt_din_r & halt_pin_assigned) | halt_fieldbus;

  assign qs_trig = qs_fieldbus |
                   (err_event & ((err_class == msj_pkg::ERR_CLASS_1) |
                                 (err_class == msj_pkg::ERR_CLASS_2)));

  // No profile forces the torque ramp
  assign qs_to_fault = (quickstop_reaction_select_r == msj_pkg::QS_TQ_FAULT) |
                       (quickstop_reaction_select_r == msj_pkg::QS_DEC_FAULT);
  assign qs_torque   = (quickstop_reaction_select_r == msj_pkg::QS_TQ_FAULT) |
                       (quickstop_reaction_select_r == msj_pkg::QS_TQ_HOLD) |
                       !mode_has_profile;
  assign halt_torque = (halt_reaction_select_r != msj_pkg::HALT_DECEL) |
                       !mode_has_profile;

  // Values outside the coded sets are refused whole
  always_comb
  begin
    addr_ok = 1'b1;
    wr_ok   = 1'b1;
    rd_val  = 32'h0;
    unique case (par_addr)
      msj_pkg::ADDR_JERK:
      begin
        rd_val = {16'h0, jerk_filter_time_r};
        wr_ok  = mode_finished &
                 (par_wdata[15:0] == 16'h0 || wr_dec[3]);
      end
      msj_pkg::ADDR_QS_RATE:
      begin
        rd_val = quickstop_decel_rate_r;
        wr_ok  = (par_wdata >= msj_pkg::QS_RATE_MIN) &&
                 (par_wdata <= msj_pkg::QS_RATE_MAX);
      end
      msj_pkg::ADDR_HALT_SEL:
      begin
        rd_val = {16'h0, halt_reaction_select_r};
        wr_ok  = (par_wdata[15:0] == msj_pkg::HALT_DECEL) ||
                 (par_wdata[15:0] == msj_pkg::HALT_TORQUE);
      end
      msj_pkg::ADDR_QS_SEL:
      begin
        rd_val = {16'h0, quickstop_reaction_select_r};
        wr_ok  = (par_wdata[15:0] == msj_pkg::QS_TQ_FAULT) ||
                 (par_wdata[15:0] == msj_pkg::QS_DEC_FAULT) ||
                 (par_wdata[15:0] == msj_pkg::QS_DEC_HOLD) ||
                 (par_wdata[15:0] == msj_pkg::QS_TQ_HOLD);
      end
      msj_pkg::ADDR_QS_ILIM:
        rd_val = {16'h0, quickstop_current_limit_r};
      msj_pkg::ADDR_HALT_ILIM:
        rd_val = {16'h0, halt_current_limit_r};
      default:
      begin
        addr_ok = 1'b0;
        wr_ok   = 1'b0;
      end
    endcase
  end

  // Parameter writes
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      jerk_filter_time_r          <= msj_pkg::JERK_RST;
      quickstop_decel_rate_r      <= msj_pkg::QS_RATE_RST;
      halt_reaction_select_r      <= msj_pkg::HALT_SEL_RST;
      quickstop_reaction_select_r <= msj_pkg::QS_SEL_RST;
      quickstop_current_limit_r   <= msj_pkg::QS_ILIM_RST;
      halt_current_limit_r        <= msj_pkg::HALT_ILIM_RST;
    end
    else if (par_req && par_we && wr_ok)
    begin
      unique case (par_addr)
        msj_pkg::ADDR_JERK:      jerk_filter_time_r          <= par_wdata[15:0];
        msj_pkg::ADDR_QS_RATE:   quickstop_decel_rate_r      <= par_wdata;
        msj_pkg::ADDR_HALT_SEL:  halt_reaction_select_r      <= par_wdata[15:0];
        msj_pkg::ADDR_QS_SEL:    quickstop_reaction_select_r <= par_wdata[15:0];
        msj_pkg::ADDR_QS_ILIM:   quickstop_current_limit_r   <= par_wdata[15:0];
        msj_pkg::ADDR_HALT_ILIM: halt_current_limit_r        <= par_wdata[15:0];
        default:                 ;
      endcase
    end
  end

  // Answer one cycle after the request
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      par_ack   <= 1'b0;
      par_err   <= 1'b0;
      par_rdata <= 32'h0;
    end
    else
    begin
      par_ack   <= par_req;
      par_err   <= par_req & (par_we ? !wr_ok : !addr_ok);
      par_rdata <= (par_req && !par_we) ? rd_val : 32'h0;
    end
  end

  // Applied at the next movement
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      jerk_act_r    <= msj_pkg::JERK_RST;
      qs_rate_act_r <= msj_pkg::QS_RATE_RST;
    end
    else if (motion_start)
    begin
      jerk_act_r    <= jerk_filter_time_r;
      qs_rate_act_r <= quickstop_decel_rate_r;
    end
  end

  // Millisecond tick for the jerk filter
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      tick_cnt_r <= 18'h0;
      tick_r     <= 1'b0;
    end
    else if (tick_cnt_r == 18'(TICK_CYCLES - 1))
    begin
      tick_cnt_r <= 18'h0;
      tick_r     <= 1'b1;
    end
    else
    begin
      tick_cnt_r <= tick_cnt_r + 18'h1;
      tick_r     <= 1'b0;
    end
  end

  assign jif.tick   = tick_r;
  assign {jif.enable, jif.shift} = jerk_decode(jerk_act_r);
  assign jif.acc_in = acc_demand;

  msj_jerk_filter u_jerk
  (
    .clk_sys (clk_sys),
    .rst     (rst),
    .jif     (jif.filt)
  );

  // Quick stop outranks halt wherever it can be taken
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      msj_pkg::ST_RUN:
        if (qs_trig)
          state_nxt = msj_pkg::ST_QS_DEC;
        else if (halt_req)
          state_nxt = msj_pkg::ST_HALT_DEC;
      msj_pkg::ST_HALT_DEC:
        if (qs_trig)
          state_nxt = msj_pkg::ST_QS_DEC;
        else if (standstill)
          state_nxt = msj_pkg::ST_HALT_STOP;
      msj_pkg::ST_HALT_STOP:
        if (qs_trig)
          state_nxt = msj_pkg::ST_QS_DEC;
        else if (!halt_req)
          state_nxt = msj_pkg::ST_RUN;
      msj_pkg::ST_QS_DEC:
        if (standstill)
          state_nxt = qs_to_fault ? msj_pkg::ST_FAULT : msj_pkg::ST_QS_HOLD;
      msj_pkg::ST_QS_HOLD,
      msj_pkg::ST_FAULT:
        if (qs_release)
          state_nxt = msj_pkg::ST_RUN;
      default:
        state_nxt = msj_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      state_r <= msj_pkg::ST_RUN;
    else
      state_r <= state_nxt;
  end

  // Selectors act at once
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      halt_active        <= 1'b0;
      qs_active          <= 1'b0;
      stop_active        <= 1'b0;
      stop_use_torque    <= 1'b0;
      stop_decel_rate    <= 32'h0;
      stop_current_limit <= 16'h0;
      resume_pulse       <= 1'b0;
    end
    else
    begin
      halt_active  <= (state_nxt == msj_pkg::ST_HALT_DEC) ||
                      (state_nxt == msj_pkg::ST_HALT_STOP);
      qs_active    <= (state_nxt == msj_pkg::ST_QS_DEC) ||
                      (state_nxt == msj_pkg::ST_QS_HOLD) ||
                      (state_nxt == msj_pkg::ST_FAULT);
      stop_active  <= (state_nxt != msj_pkg::ST_RUN);
      resume_pulse <= (state_r == msj_pkg::ST_HALT_STOP) &&
                      (state_nxt == msj_pkg::ST_RUN);
      if ((state_nxt == msj_pkg::ST_HALT_DEC) || (state_nxt == msj_pkg::ST_HALT_STOP))
      begin
        stop_use_torque    <= halt_torque;
        stop_decel_rate    <= profile_decel_rate;
        stop_current_limit <= halt_current_limit_r;
      end
      else if (state_nxt != msj_pkg::ST_RUN)
      begin
        stop_use_torque    <= qs_torque;
        stop_decel_rate    <= qs_rate_act_r;
        stop_current_limit <= quickstop_current_limit_r;
      end
      else
      begin
        stop_use_torque    <= 1'b0;
        stop_decel_rate    <= 32'h0;
        stop_current_limit <= 16'h0;
      end
    end
  end

  // State request held while parked after quick stop
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      op_state_req   <= 4'h0;
      op_state_valid <= 1'b0;
    end
    else
    begin
      op_state_valid <= (state_nxt == msj_pkg::ST_QS_HOLD) ||
                        (state_nxt == msj_pkg::ST_FAULT);
      unique case (state_nxt)
        msj_pkg::ST_QS_HOLD: op_state_req <= msj_pkg::OPST_QS_ACTIVE;
        msj_pkg::ST_FAULT:   op_state_req <= msj_pkg::OPST_FAULT;
        default:             op_state_req <= 4'h0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      jerk_time_active <= msj_pkg::JERK_RST;
    else
      jerk_time_active <= jerk_act_r;
  end

  // Registered inside the filter
  assign acc_filtered = jif.acc_out;

endmodule
